// ==== clock_source_status_pll_config_bench.sv ====
// Self-checking bench for the clock source, status and PLL ratio block.
`timescale 1ns/1ps

module clock_source_status_pll_config_bench import csspc_pkg::*;;
  logic           clk, rst_n, wb_ack, wdg_enabled, ext_stop_n, aux_on;
  logic           ce = 1'b1;       // Clock enable, stuttered on request.
  logic           stutter = 1'b0;  // Ask for a random clock enable.
  logic           rst_cause_wdg, rst_cause_soft, aux_clk_present;
  logic           pll_lock_raw;
  logic [2:0]     ev;              // Halt, wait and wake pulses.
  logic [7:0]     lock_delay, d;
  logic [31:0]    wb_dat_o, q;
  csspc_wb_req_t  wb_req;
  csspc_clk_out_t clk_ctl;
  int             n_mismatch, samples_checked, n_irq, k, cycles, n_sres;

  csspc_clock_source u_csspc_clock_source (
    .clk(clk), .rst_n(rst_n), .ce(ce), .wb_req(wb_req), .wb_ack(wb_ack),
    .wb_dat_o(wb_dat_o), .rst_cause_wdg(rst_cause_wdg),
    .rst_cause_soft(rst_cause_soft), .wdg_enabled(wdg_enabled),
    .halt_instr(ev[0]), .wfi_instr(ev[1]), .wfi_wake(ev[2]),
    .aux_clk_present(aux_clk_present), .pll_lock_raw(pll_lock_raw),
    .ext_stop_n(ext_stop_n), .clk_ctl(clk_ctl));

  csspc_clock_partner u_csspc_clock_partner (
    .clk(clk), .rst_n(rst_n), .pll_en(clk_ctl.pll_en),
    .osc_en(clk_ctl.osc_en), .aux_on(aux_on), .lock_delay(lock_delay),
    .aux_present(aux_clk_present), .lock_raw(pll_lock_raw));

  // 20 MHz clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Status after reset: cause flags plus the slow divide bit.
  function automatic logic [31:0] st_rst(input logic w, input logic s);
    return {24'h0, 1'b0, w, s, 5'h08};
  endfunction

  task automatic give_verdict();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic Wishbone cycle; waits up to 60 cycles for ack, then fails the run.
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd);
    int t;
    t = 0;
    // A frozen clock enable can leave the last ack standing; let it fall.
    while (wb_ack === 1'b1) begin
      @(posedge clk);
    end
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: {22'h0, idx, 2'h0},
                sel: 4'hF, dat: {24'h0, wd}};
    do begin
      @(posedge clk);
      t++;
    end while (wb_ack !== 1'b1 && t < 60);
    if (t >= 60) begin
      n_mismatch++;
      give_verdict();
    end
    q = wb_dat_o;
    wb_req <= '0;
    @(posedge clk);
  endtask

  task automatic do_reset(input logic w, input logic s, input int hold);
    rst_n <= 1'b0;
    rst_cause_wdg <= w;
    rst_cause_soft <= s;
    repeat (hold) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  task automatic pulse(input logic [2:0] e);
    ev <= e;
    @(posedge clk);
    ev <= 3'h0;
    repeat (3) @(posedge clk);
  endtask

  // Every slow-divide change should give exactly one pulse.
  always @(posedge clk) if (clk_ctl.clk_irq === 1'b1) n_irq <= n_irq + 1;
  // Every soft reset request pulse is counted as well.
  always @(posedge clk) if (clk_ctl.soft_reset_req === 1'b1) n_sres <= n_sres + 1;
  // Clock enable drops at random cycles only while a stutter is asked for.
  always @(posedge clk) ce <= stutter ? ($urandom % 4) != 0 : 1'b1;

  // Hang guard; the run needs about a thousand cycles.
  initial begin
    cycles = 0;
    forever begin
      @(posedge clk);
      cycles++;
      if (cycles > 8000) begin
        n_mismatch++;
        give_verdict();
      end
    end
  end

  initial begin
    rst_n = 1'b0; wb_req = '0; ev = 3'h0; wdg_enabled = 1'b0;
    rst_cause_wdg = 1'b0; rst_cause_soft = 1'b0; ext_stop_n = 1'b1;
    aux_on = 1'b0; lock_delay = 8'h0A;
    n_mismatch = 0; samples_checked = 0; n_irq = 0; n_sres = 0;
    void'($urandom(12324));
    for (int i = 0; i < 3; i++) begin
      do_reset(i == 1, i == 2, 12);
      bus(1'b0, CSSPC_IDX_STATUS, 8'h00);
      check(q, st_rst(i == 1, i == 2));
    end
    bus(1'b0, CSSPC_IDX_PLLCFG, 8'h00);
    check(q, 32'h07);
    // Random ratios under a stuttering clock enable, every multiplier code.
    for (int i = 0; i < 12; i++) begin
      d = 8'($urandom);
      d[5:4] = 2'(i);
      stutter <= 1'b1;
      bus(1'b1, CSSPC_IDX_PLLCFG, d);
      bus(1'b0, CSSPC_IDX_PLLCFG, 8'h00);
      stutter <= 1'b0;
      check(q, {24'h0, d & 8'h37});
      repeat (2) @(posedge clk);
      check({clk_ctl.pll_mult, clk_ctl.pll_div}, {d[5:4], d[2:0]});
      check(clk_ctl.pll_en, d[2:0] != 3'h7);
    end
    // Power the PLL down so that the lock test below starts unlocked.
    bus(1'b1, CSSPC_IDX_PLLCFG, 8'h07);
    repeat (8) @(posedge clk);
    bus(1'b1, 8'h10, 8'hFF);
    bus(1'b0, 8'h10, 8'h00);
    check(q, 32'h0);
    // PLL on; selecting it before lock must not take.
    bus(1'b1, CSSPC_IDX_PLLCFG, 8'h01);
    bus(1'b1, CSSPC_IDX_STATUS, 8'h09);
    bus(1'b0, CSSPC_IDX_STATUS, 8'h00);
    check(q & 32'h03, 32'h0);
    repeat (40) @(posedge clk);
    bus(1'b1, CSSPC_IDX_STATUS, 8'h09);
    bus(1'b0, CSSPC_IDX_STATUS, 8'h00);
    check(q & 32'h0B, 32'h0B);
    check(32'(clk_ctl.sel), 32'(CSSPC_SEL_PLL));
    for (int i = 0; i < 2; i++) begin
      k = n_irq;
      bus(1'b1, CSSPC_IDX_STATUS, (i == 0) ? 8'h01 : 8'h08);
      repeat (2) @(posedge clk);
      check(n_irq - k, 1);
      check(32'(clk_ctl.sel), (i == 0) ? 32'h1 : 32'h0);
      bus(1'b0, CSSPC_IDX_STATUS, 8'h00);
      check(q & 32'h09, (i == 0) ? 32'h0 : 32'h08);
    end
    repeat (40) @(posedge clk);
    bus(1'b1, CSSPC_IDX_STATUS, 8'h09);
    bus(1'b1, CSSPC_IDX_PLLCFG, 8'h07);
    bus(1'b0, CSSPC_IDX_STATUS, 8'h00);
    check(q & 32'h01, 32'h0);
    ext_stop_n <= 1'b0;
    repeat (8) @(posedge clk);
    ext_stop_n <= 1'b1;
    repeat (8) @(posedge clk);
    bus(1'b1, CSSPC_IDX_STATUS, 8'h88);
    bus(1'b0, CSSPC_IDX_STATUS, 8'h00);
    check(q & 32'h80, 32'h80);
    bus(1'b1, CSSPC_IDX_STATUS, 8'h08);
    bus(1'b0, CSSPC_IDX_STATUS, 8'h00);
    check(q & 32'h80, 32'h0);
    // Aux selected but absent; halt request pending, then cancelled.
    bus(1'b1, CSSPC_IDX_CTRL, 8'h04);
    bus(1'b1, CSSPC_IDX_STATUS, 8'h18);
    bus(1'b0, CSSPC_IDX_STATUS, 8'h00);
    check(q & 32'h14, 32'h0);
    bus(1'b1, CSSPC_IDX_STATUS, 8'h08);
    aux_on <= 1'b1;
    repeat (8) @(posedge clk);
    bus(1'b0, CSSPC_IDX_STATUS, 8'h00);
    check(q & 32'h14, 32'h04);
    check({30'h0, clk_ctl.sel}, 32'(CSSPC_SEL_AUX));
    check(clk_ctl.osc_en, 1'b1);
    bus(1'b1, CSSPC_IDX_STATUS, 8'h18);
    repeat (3) @(posedge clk);
    bus(1'b0, CSSPC_IDX_STATUS, 8'h00);
    check(q & 32'h14, 32'h14);
    check({clk_ctl.osc_en, clk_ctl.osc_drive_oe_n}, 2'b01);
    aux_on <= 1'b0;
    do_reset(1'b0, 1'b0, 12);
    wdg_enabled <= 1'b1;
    pulse(3'h1);
    check(clk_ctl.osc_en, 1'b1);
    wdg_enabled <= 1'b0;
    pulse(3'h1);
    check({clk_ctl.osc_en, clk_ctl.osc_hold_high,
           clk_ctl.osc_drive_oe_n}, 3'b011);
    do_reset(1'b0, 1'b0, 400);
    check(clk_ctl.osc_en, 1'b1);
    pulse(3'h2);
    check({clk_ctl.cpu_clk_stop, clk_ctl.sel}, 3'b100);
    pulse(3'h4);
    bus(1'b1, CSSPC_IDX_CTRL, 8'h01);
    pulse(3'h2);
    check({clk_ctl.cpu_clk_stop, clk_ctl.sel}, 3'b101);
    pulse(3'h4);
    aux_on <= 1'b1;
    bus(1'b1, CSSPC_IDX_CTRL, 8'h03);
    repeat (8) @(posedge clk);
    pulse(3'h2);
    check(32'(clk_ctl.sel), 32'(CSSPC_SEL_AUX));
    // Halt with soft reset enabled only asks for a reset.
    bus(1'b1, CSSPC_IDX_CTRL, 8'h08);
    k = n_sres;
    pulse(3'h1);
    check(n_sres - k, 1);
    check(clk_ctl.osc_en, 1'b1);
    give_verdict();
  end
endmodule // clock_source_status_pll_config_bench

// ==== csspc_clock_partner.sv ====
// Behavioural model of the crystal, the PLL lock detector and the aux pin.
`timescale 1ns/1ps

module csspc_clock_partner (
  input  wire logic       clk,         // Register clock.
  input  wire logic       rst_n,       // Async reset, active low.
  input  wire logic       pll_en,      // PLL power request.
  input  wire logic       osc_en,      // Crystal running.
  input  wire logic       aux_on,      // Bench lets the aux clock run.
  input  wire logic [7:0] lock_delay,  // Lock-in time in cycles.
  output logic            aux_present, // Aux clock seen on its pin.
  output logic            lock_raw     // PLL lock detect.
);
  logic [7:0] lock_cnt_q;              // Lock-in progress.

  // Lock needs power and a running crystal for lock_delay cycles; losing
  // either drops it at once, so a slow lock can be asked for as well.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_cnt_q <= 8'h00;
      lock_raw   <= 1'b0;
    end else if (!(pll_en && osc_en)) begin
      lock_cnt_q <= 8'h00;
      lock_raw   <= 1'b0;
    end else if (lock_cnt_q < lock_delay) begin
      lock_cnt_q <= lock_cnt_q + 8'h01;
    end else begin
      lock_raw   <= 1'b1;
    end
  end

  // The pin only counts as present while its clock really runs.
  assign aux_present = aux_on;
endmodule // csspc_clock_partner

// ==== csspc_clock_source.sv ====
// Clock source selection, status flags and PLL ratio configuration.
//
// Notes on behaviour
// - Status resets by cause: watchdog, soft, power-on.
// - External stop flag sticky until software clears.
// - Bit 6 reads last reset from watchdog.
// - Bit 5 reads last reset from halt.
// - Pending halt request stops oscillator once aux selected.
// - Halt request reads zero until aux status set.
// - Writing zero cancels a pending halt request.
// - Slow divide bit picks div16 or fast path.
// - Interrupt pulse on every slow divide change.
// - Aux status only when aux present and selected.
// - Lock bit reports lock; unlocked PLL unselectable.
// - PLL select bit chooses PLL or half clock.
// - Hardware clears PLL select in five cases.
// - Aux overrides all; slow divide overrides PLL.
// - Two bit multiplier: x14, x10, x8, x6.
// - Divider code plus one; 111 means PLL off.
// - Stopped oscillator tristates the drive pin.
// - Halt stops oscillator, holds clock high, tristates.
// - Watchdog enabled keeps oscillator running on halt.
// - Low power wait picks div16 or aux clock.
// - Plain wait stops only CPU clock.
`timescale 1ns/1ps

module csspc_clock_source
  import csspc_pkg::*;
(
  input  wire logic           clk,            // 20 MHz register clock.
  input  wire logic           rst_n,          // Async reset, active low.
  input  wire logic           ce,             // Clock enable; low freezes.
  input  wire csspc_wb_req_t  wb_req,         // Wishbone request.
  output logic                wb_ack,         // Wishbone acknowledge.
  output logic [31:0]         wb_dat_o,       // Wishbone read data.
  input  wire logic           rst_cause_wdg,  // Last reset was watchdog.
  input  wire logic           rst_cause_soft, // Last reset was soft.
  input  wire logic           wdg_enabled,    // Watchdog function active.
  input  wire logic           halt_instr,     // Halt executed, pulse.
  input  wire logic           wfi_instr,      // Wait executed, pulse.
  input  wire logic           wfi_wake,       // Interrupt ends wait, pulse.
  input  wire logic           aux_clk_present,// Aux clock running, pin.
  input  wire logic           pll_lock_raw,   // PLL lock detect, async.
  input  wire logic           ext_stop_n,     // External stop pin, low.
  output csspc_clk_out_t      clk_ctl         // Clock steering outputs.
);

  // Whole state of the block in one packed record.
  typedef struct packed {
    logic           ack;       // Bus acknowledge.
    logic [7:0]     rdat;      // Registered read data.
    logic           boot;      // First cycle after reset release.
    logic           ext_stop;  // Sticky external stop flag.
    logic           wdg_flag;  // Watchdog reset cause.
    logic           soft_flag; // Soft reset cause.
    logic           halt_req;  // Oscillator stop request, pending.
    logic           slow_div;  // Fast path when set.
    logic           pll_sel;   // PLL drives the fast path.
    logic [1:0]     mult;      // Multiplier code.
    logic [2:0]     div;       // Divider code.
    logic [3:0]     ctrl;      // Control bits.
    logic           halted;    // Halt state until reset.
    logic           wfi_lp;    // Low power wait in progress.
    logic           wfi_cpu;   // CPU clock stopped by wait.
    logic [2:0]     s1;        // Synchroniser first stage.
    logic [2:0]     s2;        // Synchroniser second stage.
    logic [2:0]     s3;        // Synchroniser third stage.
    logic [2:0]     filt;      // Accepted pin levels.
    logic           stop_prev; // Previous stop pin level.
    csspc_clk_out_t out;       // Registered outputs.
  } csspc_state_t;

  csspc_state_t st_q;          // Current state.
  csspc_state_t st_d;          // Next state.

  logic       aux_sel;         // Aux requested, explicit or by wait.
  logic       aux_st;          // Aux truly selected.
  logic       osc_stop;        // Oscillator is off.
  logic       bus_req;         // New bus request this cycle.
  logic       wr_lane;         // Write to the low byte.
  logic       wr_stat;         // Write to status register.
  logic       wr_pll;          // Write to PLL configuration.
  logic       wr_ctrl;         // Write to control register.
  logic [7:0] stat_view;       // Status as software sees it.
  logic [7:0] wd;              // Low byte of write data.

  // True when the word address matches a register index.
  function automatic logic hit(input logic [31:0] a,
                               input logic [7:0]  idx);
    hit = (a[31:10] == 22'h000000) && (a[9:2] == idx);
  endfunction

  // Selection of the aux clock never happens without a clock on it.
  assign aux_sel = st_q.ctrl[CSSPC_CT_AUX_SEL] |
                   (st_q.wfi_lp & st_q.ctrl[CSSPC_CT_WFI_SEL]);
  assign aux_st  = aux_sel & st_q.filt[CSSPC_PIN_AUX];
  // A pending request only bites once the aux clock has taken over.
  assign osc_stop = st_q.halted | (st_q.halt_req & aux_st);

  // Bus decode; one new request per idle-to-busy transition.
  assign bus_req = wb_req.cyc & wb_req.stb & ~st_q.ack;
  assign wr_lane = ce & bus_req & wb_req.we & wb_req.sel[0];
  assign wr_stat = wr_lane & hit(wb_req.adr, CSSPC_IDX_STATUS);
  assign wr_pll  = wr_lane & hit(wb_req.adr, CSSPC_IDX_PLLCFG);
  assign wr_ctrl = wr_lane & hit(wb_req.adr, CSSPC_IDX_CTRL);
  assign wd      = wb_req.dat[7:0];

  // Status view; the halt bit stays hidden while still pending.
  assign stat_view = {st_q.ext_stop,
                      st_q.wdg_flag,
                      st_q.soft_flag,
                      st_q.halt_req & aux_st,
                      st_q.slow_div,
                      aux_st,
                      st_q.filt[CSSPC_PIN_LOCK],
                      st_q.pll_sel};

  // Next-state logic for the whole block.
  always_comb begin
    st_d = st_q;
    // Pin synchronisers; a change counts once stages two and three agree.
    st_d.s1 = {~ext_stop_n, pll_lock_raw, aux_clk_present};
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.filt = ((st_q.s2 ~^ st_q.s3) & st_q.s3) |
                (~(st_q.s2 ~^ st_q.s3) & st_q.filt);
    st_d.stop_prev = st_q.filt[CSSPC_PIN_STOP];

    // Bus answer is one cycle after the request is seen.
    st_d.ack  = bus_req;
    st_d.rdat = 8'h00;
    if (bus_req && !wb_req.we) begin
      if (hit(wb_req.adr, CSSPC_IDX_STATUS)) begin
        st_d.rdat = stat_view;
      end else if (hit(wb_req.adr, CSSPC_IDX_PLLCFG)) begin
        st_d.rdat = {2'h0, st_q.mult, 1'b0, st_q.div};
      end else if (hit(wb_req.adr, CSSPC_IDX_CTRL)) begin
        st_d.rdat = {4'h0, st_q.ctrl};
      end
    end

    // Reset cause is caught on the first cycle after release.
    st_d.boot = 1'b0;
    if (st_q.boot) begin
      st_d.wdg_flag  = rst_cause_wdg;
      st_d.soft_flag = rst_cause_soft;
    end

    // Software writes.
    if (wr_ctrl) begin
      st_d.ctrl = wd[3:0];
    end
    if (wr_pll) begin
      st_d.mult = wd[CSSPC_PC_MULT_LO +: 2];
      st_d.div  = wd[CSSPC_PC_DIV_LO +: 3];
    end
    if (wr_stat) begin
      // Writing zero clears the flag; writing one leaves it alone.
      if (!wd[CSSPC_ST_EXT_STOP]) begin
        st_d.ext_stop = 1'b0;
      end
      // A read-modify-write that returns zero cancels the request.
      st_d.halt_req = wd[CSSPC_ST_HALT_EN];
      st_d.slow_div = wd[CSSPC_ST_SLOW_DIV];
      // The select is dropped again below while the PLL is not locked.
      st_d.pll_sel = wd[CSSPC_ST_PLL_SEL];
    end

    // External stop edge sets the flag; set wins over the clear.
    if (st_q.filt[CSSPC_PIN_STOP] && !st_q.stop_prev) begin
      st_d.ext_stop = 1'b1;
    end

    // Wait handling; plain wait only stops the CPU clock.
    if (wfi_instr) begin
      st_d.wfi_cpu = 1'b1;
      if (st_q.ctrl[CSSPC_CT_LP_WFI]) begin
        st_d.wfi_lp = 1'b1;
      end
    end else if (wfi_wake) begin
      st_d.wfi_cpu = 1'b0;
      st_d.wfi_lp  = 1'b0;
    end

    // Halt: watchdog keeps the oscillator alive, else reset or stop.
    if (halt_instr && !st_q.halted && !wdg_enabled) begin
      if (!st_q.ctrl[CSSPC_CT_SRES_EN]) begin
        st_d.halted = 1'b1;
      end
    end

    // Hardware clears of the PLL selection; unlocked PLL never drives.
    if ((wr_pll && wd[CSSPC_PC_DIV_LO +: 3] == CSSPC_DIV_OFF) ||
        osc_stop ||
        (wfi_instr && st_q.ctrl[CSSPC_CT_LP_WFI]) ||
        !st_d.slow_div ||
        !st_q.filt[CSSPC_PIN_LOCK]) begin
      st_d.pll_sel = 1'b0;
    end

    // Registered outputs, from the present state, the halt inputs and the next slow divide bit.
    if (aux_st) begin
      st_d.out.sel = CSSPC_SEL_AUX;
    end else if (st_q.wfi_lp || !st_q.slow_div) begin
      st_d.out.sel = CSSPC_SEL_DIV16;
    end else if (st_q.pll_sel) begin
      st_d.out.sel = CSSPC_SEL_PLL;
    end else begin
      st_d.out.sel = CSSPC_SEL_HALF;
    end
    // PLL runs only on the fast path with a real divider code.
    st_d.out.pll_en = st_q.slow_div && st_q.div != CSSPC_DIV_OFF &&
                      !st_q.wfi_lp && !osc_stop;
    st_d.out.pll_mult = st_q.mult;
    st_d.out.pll_div  = st_q.div;
    st_d.out.osc_en   = !osc_stop;
    st_d.out.osc_hold_high  = st_q.halted;
    st_d.out.osc_drive_oe_n = osc_stop;
    st_d.out.cpu_clk_stop   = st_q.wfi_cpu;
    st_d.out.soft_reset_req = halt_instr && !st_q.halted &&
                              !wdg_enabled &&
                              st_q.ctrl[CSSPC_CT_SRES_EN];
    // Either direction of the slow divide bit raises a request.
    st_d.out.clk_irq = st_d.slow_div != st_q.slow_div;
  end

  // State register; the clock enable freezes everything.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q            <= '0;
      st_q.boot       <= 1'b1;
      st_q.slow_div   <= CSSPC_STATUS_RST[CSSPC_ST_SLOW_DIV];
      st_q.mult       <= CSSPC_PLLCFG_RST[CSSPC_PC_MULT_LO +: 2];
      st_q.div        <= CSSPC_PLLCFG_RST[CSSPC_PC_DIV_LO +: 3];
      st_q.ctrl       <= CSSPC_CTRL_RST;
      st_q.out.osc_en <= 1'b1;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // Outputs come straight from the state flops.
  assign wb_ack   = st_q.ack;
  assign wb_dat_o = {24'h000000, st_q.rdat};
  assign clk_ctl  = st_q.out;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Reset cause is loaded on the release cycle.
  chk_reset_cause_load: assert property (
    ce && st_q.boot |=> st_q.wdg_flag == $past(rst_cause_wdg) &&
                        st_q.soft_flag == $past(rst_cause_soft))
    else $error("reset cause flags not loaded");

  // External stop edge sets the sticky flag.
  chk_ext_stop_set: assert property (
    ce && st_q.filt[CSSPC_PIN_STOP] && !st_q.stop_prev |=> st_q.ext_stop)
    else $error("external stop flag not set");

  // Halt bit stays hidden while aux is not selected.
  chk_halt_hidden: assert property (
    ce && bus_req && !wb_req.we && hit(wb_req.adr, CSSPC_IDX_STATUS) &&
    !aux_st |=> !wb_dat_o[CSSPC_ST_HALT_EN])
    else $error("halt bit visible while pending");

  // Writing zero cancels the request.
  chk_halt_cancel: assert property (
    wr_stat && !wd[CSSPC_ST_HALT_EN] |=> !st_q.halt_req ##1 !osc_stop)
    else $error("halt request not cancelled");

  // Interrupt pulse goes with every change of slow divide.
  chk_irq_toggle: assert property (
    ce |=> st_q.out.clk_irq == (st_q.slow_div != $past(st_q.slow_div)))
    else $error("interrupt not tied to slow divide change");

  // Unlocked PLL is never selected.
  chk_pll_unlock: assert property (
    ce && !st_q.filt[CSSPC_PIN_LOCK] |=> !st_q.pll_sel)
    else $error("unlocked PLL selected");

  // Divider code 111 clears the PLL selection.
  chk_pll_clear: assert property (
    wr_pll && wd[2:0] == CSSPC_DIV_OFF |=> !st_q.pll_sel)
    else $error("PLL select not cleared");

  // Aux clock wins over every other source.
  chk_aux_prio: assert property (
    ce && aux_st |=> st_q.out.sel == CSSPC_SEL_AUX)
    else $error("aux clock not given priority");

  // Stopped oscillator tristates its drive pin.
  chk_osc_tristate: assert property (
    ce && osc_stop |=> st_q.out.osc_drive_oe_n && !st_q.out.osc_en)
    else $error("drive pin not tristated");

  // Halt holds the clock high and tristates the pin.
  chk_halt_osc: assert property (
    ce && halt_instr && !wdg_enabled && !st_q.ctrl[CSSPC_CT_SRES_EN]
    |=> st_q.halted ##1 st_q.out.osc_hold_high && st_q.out.osc_drive_oe_n)
    else $error("halt did not stop oscillator");

  // Watchdog keeps the oscillator running on halt.
  chk_wdg_halt: assert property (
    ce && halt_instr && wdg_enabled && !st_q.halted |=> !st_q.halted)
    else $error("halt stopped oscillator under watchdog");

  // Halt with soft reset enabled asks for a reset and keeps running.
  chk_soft_reset_req: assert property (
    ce && halt_instr && !wdg_enabled && !st_q.halted &&
    st_q.ctrl[CSSPC_CT_SRES_EN] |=> st_q.out.soft_reset_req && !st_q.halted)
    else $error("soft reset not requested on halt");

  // Slow divide at zero keeps the PLL powered down.
  chk_slow_pll_off: assert property (
    ce && !st_q.slow_div |=> !st_q.out.pll_en)
    else $error("PLL powered while slow divide is zero");

  // Main scenarios.
  cov_pll_run: cover property (st_q.out.sel == CSSPC_SEL_PLL);
  cov_soft_reset: cover property (st_q.out.soft_reset_req);
  cov_aux_stop: cover property (aux_st && osc_stop);
  cov_lp_wait: cover property (st_q.wfi_lp ##1 !st_q.wfi_lp);

endmodule // csspc_clock_source

// ==== csspc_pkg.sv ====
// Package with register map, field layout and types of the clock source block.
package csspc_pkg;

  // Register indices; byte address is four times the index.
  localparam logic [7:0] CSSPC_IDX_CTRL   = 8'hF0;
  localparam logic [7:0] CSSPC_IDX_STATUS = 8'hF2;
  localparam logic [7:0] CSSPC_IDX_PLLCFG = 8'hF6;

  // Status register bit positions.
  localparam int CSSPC_ST_EXT_STOP = 7;
  localparam int CSSPC_ST_WDG      = 6;
  localparam int CSSPC_ST_SOFT     = 5;
  localparam int CSSPC_ST_HALT_EN  = 4;
  localparam int CSSPC_ST_SLOW_DIV = 3;
  localparam int CSSPC_ST_AUX      = 2;
  localparam int CSSPC_ST_LOCK     = 1;
  localparam int CSSPC_ST_PLL_SEL  = 0;

  // PLL configuration field positions.
  localparam int CSSPC_PC_MULT_LO = 4;
  localparam int CSSPC_PC_DIV_LO  = 0;

  // Control register bit positions.
  localparam int CSSPC_CT_SRES_EN = 3;
  localparam int CSSPC_CT_AUX_SEL = 2;
  localparam int CSSPC_CT_WFI_SEL = 1;
  localparam int CSSPC_CT_LP_WFI  = 0;

  // Reset values.
  localparam logic [7:0] CSSPC_STATUS_RST = 8'h08;
  localparam logic [7:0] CSSPC_PLLCFG_RST = 8'h07;
  localparam logic [3:0] CSSPC_CTRL_RST   = 4'h0;
  localparam logic [2:0] CSSPC_DIV_OFF    = 3'h7;

  // Multiplier codes: x14, x10, x8, x6.
  localparam logic [1:0] CSSPC_MUL_14 = 2'h2;
  localparam logic [1:0] CSSPC_MUL_10 = 2'h0;
  localparam logic [1:0] CSSPC_MUL_8  = 2'h3;
  localparam logic [1:0] CSSPC_MUL_6  = 2'h1;

  // Positions of the pins in the synchroniser vector.
  localparam int CSSPC_PIN_AUX  = 0;
  localparam int CSSPC_PIN_LOCK = 1;
  localparam int CSSPC_PIN_STOP = 2;

  // System clock source choice.
  typedef enum logic [1:0] {
    CSSPC_SEL_HALF  = 2'b00,
    CSSPC_SEL_DIV16 = 2'b01,
    CSSPC_SEL_PLL   = 2'b10,
    CSSPC_SEL_AUX   = 2'b11
  } csspc_clksel_t;

  // Classic Wishbone request from the master.
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [31:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } csspc_wb_req_t;

  // Clock steering outputs towards oscillator, PLL and CPU.
  typedef struct packed {
    csspc_clksel_t sel;
    logic          pll_en;
    logic [1:0]    pll_mult;
    logic [2:0]    pll_div;
    logic          osc_en;
    logic          osc_hold_high;
    logic          osc_drive_oe_n;
    logic          cpu_clk_stop;
    logic          soft_reset_req;
    logic          clk_irq;
  } csspc_clk_out_t;

endpackage
